// *** logic/gb_cfg.svh ***
`ifndef GB_CFG_SVH
`define GB_CFG_SVH
// Operation
// - Burst access walks the counted registers in sequence from the pointer
// - Pointer selects single register or contiguous range
// - Data register latches after sixteenth bit
// - Control register latches after first byte
// - Every access starts at current pointer
// - Pointer advances by one per byte pair
// - Scattered registers need one full transaction each
// - Control at zero, DAC data one to fifteen
// - Control bit 11 disables outputs, default zero
// - Control byte 0x06 recalls stored data
// - Recall command byte is not acknowledged
// - Store flag chooses DAC only or both
// - Reserved data bits written and read zero
// - Master never writes pointers 0x10 and above
// - Nonvolatile write completes within 35 ms
// - Master spaces nonvolatile writes 35 ms apart
// - Answer only address 0x74 or 0x75 by pin
// - Second byte at pointer zero is ignored
// - Most significant byte first in each pair

// Bus address and register map
`define GB_ADDR_HI     6'h3a
`define GB_PTR_CTRL    8'h00
`define GB_REG_SPAN    9'h010
`define GB_CMD_RECALL  8'h06
`define GB_DIS_BIT     3
`define GB_NVW_BIT     6
`define GB_MSB_MASK    8'h43

// Nonvolatile write time
`define GB_NV_MS       35
`define GB_CLK_KHZ     200000
`define GB_NV_CYC      (`GB_NV_MS * `GB_CLK_KHZ)

// Controller registers on APB
`define GB_REG_CMD     12'h000
`define GB_REG_STAT    12'h004
`define GB_REG_DIV     12'h008
`define GB_REG_BUF     6'h01
`define GB_CMD_GO      0
`define GB_CMD_RD      1
`define GB_CMD_PTR     8
`define GB_CMD_CNT     16
`define GB_CMD_A0      24
`define GB_MAX_CNT     5'h10
`define GB_DIV_RST     16'h007d
`endif

// *** logic/gb_pkg.sv ***
`default_nettype none
package gb_pkg;
  typedef enum logic [2:0] {
    GB_D_IDLE = 3'b001,
    GB_D_RX   = 3'b010,
    GB_D_TX   = 3'b100
  } gb_dstate_e;
  typedef enum logic [3:0] {
    GB_H_IDLE  = 4'b0001,
    GB_H_START = 4'b0010,
    GB_H_BIT   = 4'b0100,
    GB_H_STOP  = 4'b1000
  } gb_hstate_e;
  typedef enum logic [4:0] {
    GB_P_ADDR_W = 5'b00001,
    GB_P_PTR    = 5'b00010,
    GB_P_WDATA  = 5'b00100,
    GB_P_ADDR_R = 5'b01000,
    GB_P_RDATA  = 5'b10000
  } gb_phase_e;
  typedef enum logic [2:0] {
    GB_R_NONE = 3'h0,
    GB_R_CMD  = 3'h1,
    GB_R_STAT = 3'h2,
    GB_R_DIV  = 3'h3,
    GB_R_BUF  = 3'h4
  } gb_reg_e;
endpackage
`default_nettype wire

// *** logic/gb_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface gb_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;
  // Open-drain wire with pull-up: low while any enabled driver pulls low
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

// *** logic/gb_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gb_cfg.svh"
module gb_dev
  import gb_pkg::*;
#(
  parameter int unsigned NCH    = 15,
  parameter int unsigned NV_CYC = `GB_NV_CYC
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  gb_link_if.slave              link,
  input  wire logic             address_select_pin,
  output logic                  outputs_disabled,
  output logic [NCH*10-1:0]     dac_values,
  output logic                  nv_busy
);
  function automatic logic is_dac(input logic [7:0] p);
    is_dac = (p != `GB_PTR_CTRL) && (p <= 8'(NCH));
  endfunction

  logic [1:0]  scl_sy_q, sda_sy_q, a0_sy_q;
  logic        scl_l_q, sda_l_q;
  logic        scl_s, sda_s, rise, fall, start, stop;
  gb_dstate_e  st_q;
  logic [3:0]  cnt_q;
  logic [1:0]  bno_q;
  logic        half_q, rdreq_q, ack_q, dis_q, sda_oe_q;
  logic [7:0]  ptr_q, sh_q, tsh_q, msb_q;
  logic [7:0]  rx_byte, rd_byte;
  logic [15:0] rd_word;
  logic        rx_done, data_rx, do_ctrl, do_recall, do_dac, addr_hit, tx_load;
  logic        nvb_q, nv_done;
  logic [31:0] nvc_q;
  logic [3:0]  nvi_q;
  logic [9:0]  nvd_q;
  logic [9:0]  dac_q [1:NCH];
  logic [9:0]  nv_q  [1:NCH];

  // Bus lines are asynchronous to clk; edges are judged only after two stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      a0_sy_q  <= 2'h0;
      scl_l_q  <= 1'b1;
      sda_l_q  <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], link.scl};
      sda_sy_q <= {sda_sy_q[0], link.sda};
      a0_sy_q  <= {a0_sy_q[0], address_select_pin};
      scl_l_q  <= scl_sy_q[1];
      sda_l_q  <= sda_sy_q[1];
    end
  end

  assign scl_s = scl_sy_q[1];
  assign sda_s = sda_sy_q[1];
  assign rise  = scl_s && !scl_l_q;
  assign fall  = !scl_s && scl_l_q;
  assign start = scl_s && scl_l_q && sda_l_q && !sda_s;
  assign stop  = scl_s && scl_l_q && !sda_l_q && sda_s;

  assign rx_byte   = {sh_q[6:0], sda_s};
  assign rx_done   = rise && (st_q == GB_D_RX) && (cnt_q == 4'h7);
  assign data_rx   = rx_done && (bno_q == 2'h2);
  assign do_ctrl   = data_rx && (ptr_q == `GB_PTR_CTRL) && !half_q;
  assign do_recall = do_ctrl && (rx_byte == `GB_CMD_RECALL);
  assign do_dac    = data_rx && is_dac(ptr_q) && half_q;
  assign addr_hit  = (rx_byte[7:1] == {`GB_ADDR_HI, a0_sy_q[1]});
  assign tx_load   = fall && (cnt_q == 4'h8) && ((st_q == GB_D_TX) || ((st_q == GB_D_RX) && rdreq_q));

  // Read image: reserved bits and unmapped pointers return zero
  always_comb begin
    rd_word = 16'h0000;
    if (ptr_q == `GB_PTR_CTRL) begin
      rd_word[8+`GB_DIS_BIT] = dis_q;
    end else if (is_dac(ptr_q)) begin
      rd_word[9:0] = dac_q[ptr_q[3:0]];
    end
  end
  assign rd_byte = half_q ? rd_word[7:0] : rd_word[15:8];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= GB_D_IDLE;
      cnt_q   <= 4'h0;
      bno_q   <= 2'h0;
      half_q  <= 1'b0;
      rdreq_q <= 1'b0;
      ack_q   <= 1'b0;
      ptr_q   <= 8'h00;
      sh_q    <= 8'h00;
      tsh_q   <= 8'h00;
    end else if (start) begin
      st_q    <= GB_D_RX;
      // The scl fall that closes the start condition wraps the count to zero
      cnt_q   <= 4'hf;
      bno_q   <= 2'h0;
      half_q  <= 1'b0;
      rdreq_q <= 1'b0;
    end else if (stop) begin
      st_q <= GB_D_IDLE;
    end else begin
      if (rise) begin
        sh_q <= rx_byte;
      end
      case (st_q)
        GB_D_RX: begin
          if (fall) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
          end
          if (rx_done) begin
            ack_q <= 1'b1;
            bno_q <= (bno_q == 2'h2) ? 2'h2 : bno_q + 2'h1;
            case (bno_q)
              2'h0: begin
                if (!addr_hit) begin
                  st_q <= GB_D_IDLE;
                end
                rdreq_q <= rx_byte[0];
              end
              2'h1: begin
                ptr_q  <= rx_byte;
                half_q <= 1'b0;
              end
              default: begin
                half_q <= !half_q;
                if (half_q) begin
                  ptr_q <= ptr_q + 8'h01;
                end
                ack_q <= !do_recall;
              end
            endcase
          end
          if (tx_load) begin
            st_q <= GB_D_TX;
          end
        end
        GB_D_TX: begin
          if (rise && (cnt_q == 4'h8) && sda_s) begin
            st_q <= GB_D_IDLE;
          end
          if (fall) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            tsh_q <= {tsh_q[6:0], 1'b0};
          end
        end
        default: begin
        end
      endcase
      if (tx_load) begin
        tsh_q  <= rd_byte;
        half_q <= !half_q;
        if (half_q) begin
          ptr_q <= ptr_q + 8'h01;
        end
      end
    end
  end

  // Pin drive follows state one cycle late, well inside the low half of scl
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= ((st_q == GB_D_TX) && (cnt_q != 4'h8) && !tsh_q[7]) ||
                  ((st_q == GB_D_RX) && (cnt_q == 4'h8) && ack_q);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dis_q <= 1'b0;
      msb_q <= 8'h00;
    end else begin
      if (do_ctrl) begin
        dis_q <= rx_byte[`GB_DIS_BIT];
      end
      if (data_rx && !half_q && is_dac(ptr_q)) begin
        msb_q <= rx_byte;
      end
    end
  end

  // One store write in flight; a second flagged write meanwhile updates the DAC only
  assign nv_done = nvb_q && (nvc_q == 32'h0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvb_q <= 1'b0;
      nvc_q <= 32'h0;
      nvi_q <= 4'h0;
      nvd_q <= 10'h000;
    end else if (do_dac && msb_q[`GB_NVW_BIT] && !nvb_q) begin
      nvb_q <= 1'b1;
      nvc_q <= 32'(NV_CYC - 1);
      nvi_q <= ptr_q[3:0];
      nvd_q <= {msb_q[1:0], rx_byte};
    end else if (nv_done) begin
      nvb_q <= 1'b0;
    end else if (nvb_q) begin
      nvc_q <= nvc_q - 32'h1;
    end
  end

  for (genvar i = 1; i <= NCH; i++) begin : g_ch
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        dac_q[i] <= 10'h000;
      end else if (do_recall) begin
        dac_q[i] <= nv_q[i];
      end else if (do_dac && (ptr_q[3:0] == 4'(i))) begin
        dac_q[i] <= {msb_q[1:0], rx_byte};
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        nv_q[i] <= 10'h000;
      end else if (nv_done && (nvi_q == 4'(i))) begin
        nv_q[i] <= nvd_q;
      end
    end
    assign dac_values[(i-1)*10 +: 10] = dac_q[i];
  end

  assign outputs_disabled = dis_q;
  assign nv_busy          = nvb_q;
  assign link.s_sda_oe    = sda_oe_q;
  assign link.s_sda_o     = 1'b0;
endmodule
`default_nettype wire

// *** logic/gb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gb_cfg.svh"
module gb_host
  import gb_pkg::*;
#(
  parameter logic [15:0] DIV_RST = `GB_DIV_RST,
  parameter int unsigned NV_CYC  = `GB_NV_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  gb_link_if.master        link
);
  function automatic gb_reg_e dec(input logic [11:0] a);
    if (a == `GB_REG_CMD) dec = GB_R_CMD;
    else if (a == `GB_REG_STAT) dec = GB_R_STAT;
    else if (a == `GB_REG_DIV) dec = GB_R_DIV;
    else if ((a[11:6] == `GB_REG_BUF) && (a[1:0] == 2'h0)) dec = GB_R_BUF;
    else dec = GB_R_NONE;
  endfunction

  gb_hstate_e  hst_q;
  gb_phase_e   ph_q;
  logic        pready_q, pslverr_q, rd_q, a0_q, nack_q, rej_q, nvw_q, scl_q, oe_q, ackin_q;
  logic [31:0] prdata_q, rdata, guard_q;
  logic [15:0] div_q, dcnt_q;
  logic [15:0] buf_q [0:15];
  logic [7:0]  ptr_q, tx_q, rx_q, wbyte, wreg;
  logic [4:0]  cnt_q, k_q, nk;
  logic [3:0]  bit_q;
  logic [1:0]  q_q, sda_sy_q;
  logic        acc_w, go, rej, tick, bend, rxm, last, sda_s;

  assign sda_s = sda_sy_q[1];
  assign acc_w = psel && penable && pready_q && pwrite;
  // Writes that run past the bank or come too soon after a store write are refused
  assign rej   = (pwdata[`GB_CMD_CNT +: 5] > `GB_MAX_CNT) || (!pwdata[`GB_CMD_RD] &&
                 (({1'b0, pwdata[`GB_CMD_PTR +: 8]} + {4'h0, pwdata[`GB_CMD_CNT +: 5]} > `GB_REG_SPAN) ||
                 (guard_q != 32'h0)));
  assign go    = acc_w && (dec(paddr) == GB_R_CMD) && pwdata[`GB_CMD_GO] && (hst_q == GB_H_IDLE);
  assign tick  = (dcnt_q == 16'h0000);
  assign rxm   = (ph_q == GB_P_RDATA);
  assign last  = ({1'b0, k_q} == ({cnt_q, 1'b0} - 6'h01));
  assign bend  = tick && (hst_q == GB_H_BIT) && (q_q == 2'h3) && (bit_q == 4'h8);
  assign nk    = (ph_q == GB_P_WDATA) ? k_q + 5'h01 : 5'h00;
  assign wreg  = ptr_q + {4'h0, nk[4:1]};
  // Most significant byte of each pair goes first; reserved DAC bits forced to zero
  assign wbyte = nk[0] ? buf_q[nk[4:1]][7:0] :
                 ((wreg == `GB_PTR_CTRL) ? buf_q[nk[4:1]][15:8] : buf_q[nk[4:1]][15:8] & `GB_MSB_MASK);

  always_comb begin
    case (dec(paddr))
      GB_R_CMD:  rdata = {7'h00, a0_q, 3'h0, cnt_q, ptr_q, 6'h00, rd_q, 1'b0};
      GB_R_STAT: rdata = {29'h0, rej_q, nack_q, hst_q != GB_H_IDLE};
      GB_R_DIV:  rdata = {16'h0000, div_q};
      GB_R_BUF:  rdata = {16'h0000, buf_q[paddr[5:2]]};
      default:   rdata = 32'h0;
    endcase
  end

  // Fixed answer: pready in the first access cycle, read data captured in setup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q <= psel && !penable && !pready_q;
      if (psel && !penable) begin
        prdata_q  <= rdata;
        pslverr_q <= (dec(paddr) == GB_R_NONE);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q   <= 1'b0;
      a0_q   <= 1'b0;
      ptr_q  <= 8'h00;
      cnt_q  <= 5'h00;
      div_q  <= DIV_RST;
      nack_q <= 1'b0;
      rej_q  <= 1'b0;
    end else begin
      if (acc_w && (dec(paddr) == GB_R_DIV)) begin
        div_q <= pwdata[15:0];
      end
      if (go) begin
        rej_q  <= rej;
        nack_q <= 1'b0;
        if (!rej) begin
          rd_q  <= pwdata[`GB_CMD_RD];
          a0_q  <= pwdata[`GB_CMD_A0];
          ptr_q <= pwdata[`GB_CMD_PTR +: 8];
          cnt_q <= pwdata[`GB_CMD_CNT +: 5];
        end
      end else if (bend && !rxm && ackin_q) begin
        nack_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        buf_q[i] <= 16'h0000;
      end
    end else if (acc_w && (dec(paddr) == GB_R_BUF)) begin
      buf_q[paddr[5:2]] <= pwdata[15:0];
    end else if (bend && rxm) begin
      if (k_q[0]) begin
        buf_q[k_q[4:1]][7:0] <= rx_q;
      end else begin
        buf_q[k_q[4:1]][15:8] <= rx_q;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_sy_q <= 2'h3;
      dcnt_q   <= 16'h0000;
      q_q      <= 2'h0;
      guard_q  <= 32'h0;
    end else begin
      sda_sy_q <= {sda_sy_q[0], link.sda};
      dcnt_q   <= ((hst_q == GB_H_IDLE) || tick) ? div_q - 16'h0001 : dcnt_q - 16'h0001;
      q_q      <= (hst_q == GB_H_IDLE) ? 2'h0 : q_q + {1'b0, tick};
      if (tick && (hst_q == GB_H_STOP) && (q_q == 2'h3) && nvw_q) begin
        guard_q <= NV_CYC;
      end else if (guard_q != 32'h0) begin
        guard_q <= guard_q - 32'h1;
      end
    end
  end

  // Each bit is four quarters: set data, raise scl, sample, lower scl
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hst_q   <= GB_H_IDLE;
      ph_q    <= GB_P_ADDR_W;
      scl_q   <= 1'b1;
      oe_q    <= 1'b0;
      bit_q   <= 4'h0;
      k_q     <= 5'h00;
      tx_q    <= 8'h00;
      rx_q    <= 8'h00;
      ackin_q <= 1'b0;
      nvw_q   <= 1'b0;
    end else if (go && !rej) begin
      hst_q <= GB_H_START;
      ph_q  <= GB_P_ADDR_W;
    end else if (tick) begin
      case (hst_q)
        GB_H_START: begin
          case (q_q)
            2'h0: begin
              scl_q <= 1'b0;
              oe_q  <= 1'b0;
            end
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b1;
            default: begin
              scl_q <= 1'b0;
              hst_q <= GB_H_BIT;
              bit_q <= 4'h0;
              tx_q  <= {`GB_ADDR_HI, a0_q, ph_q == GB_P_ADDR_R};
            end
          endcase
        end
        GB_H_BIT: begin
          case (q_q)
            2'h0: oe_q <= (bit_q == 4'h8) ? (rxm && !last) : (!rxm && !tx_q[7]);
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q == 4'h8) begin
                ackin_q <= sda_s;
              end else begin
                rx_q <= {rx_q[6:0], sda_s};
              end
            end
            default: begin
              scl_q <= 1'b0;
              if (bit_q != 4'h8) begin
                bit_q <= bit_q + 4'h1;
                tx_q  <= {tx_q[6:0], 1'b0};
              end else begin
                bit_q <= 4'h0;
                if (!rxm && ackin_q) begin
                  hst_q <= GB_H_STOP;
                end else begin
                  case (ph_q)
                    GB_P_ADDR_W: begin
                      ph_q <= GB_P_PTR;
                      tx_q <= ptr_q;
                    end
                    GB_P_PTR: begin
                      if (cnt_q == 5'h00) begin
                        hst_q <= GB_H_STOP;
                      end else if (rd_q) begin
                        ph_q  <= GB_P_ADDR_R;
                        hst_q <= GB_H_START;
                      end else begin
                        ph_q <= GB_P_WDATA;
                        k_q  <= 5'h00;
                        tx_q <= wbyte;
                        nvw_q <= nvw_q | ((wreg != `GB_PTR_CTRL) && wbyte[`GB_NVW_BIT]);
                      end
                    end
                    GB_P_ADDR_R: begin
                      ph_q <= GB_P_RDATA;
                      k_q  <= 5'h00;
                    end
                    default: begin
                      if (last) begin
                        hst_q <= GB_H_STOP;
                      end else begin
                        k_q  <= k_q + 5'h01;
                        tx_q <= wbyte;
                        if (!rxm && !nk[0]) begin
                          nvw_q <= nvw_q | ((wreg != `GB_PTR_CTRL) && wbyte[`GB_NVW_BIT]);
                        end
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        GB_H_STOP: begin
          case (q_q)
            2'h0: oe_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b0;
            default: begin
              hst_q <= GB_H_IDLE;
              nvw_q <= 1'b0;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign link.scl      = scl_q;
  assign link.m_sda_oe = oe_q;
  assign link.m_sda_o  = 1'b0;
endmodule
`default_nettype wire

// *** verif/gb_link_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gb_cfg.svh"
module gb_link_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic sda,
  input wire logic address_select_pin
);
  logic       scl_q;
  logic       sda_q;
  logic       frm_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q;
  logic [7:0] adr_q;
  logic [7:0] ptr_q;
  wire logic  rise;
  wire logic  start;
  wire logic  stop;
  wire logic  slot;
  wire logic  hit;
  wire logic  wr_ok;
  wire logic  recall;
  assign rise   = scl && !scl_q;
  assign start  = scl && scl_q && sda_q && !sda;
  assign stop   = scl && scl_q && !sda_q && sda;
  assign slot   = rise && bit_q == 4'h8;
  assign hit    = sh_q[7:1] == {`GB_ADDR_HI, address_select_pin};
  assign wr_ok  = adr_q == {`GB_ADDR_HI, address_select_pin, 1'b0};
  assign recall = byte_q == 3'h2 && ptr_q == `GB_PTR_CTRL && sh_q == `GB_CMD_RECALL;

  // Bit and byte position of the frame, rebuilt from the wire alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      frm_q  <= 1'b0;
      bit_q  <= 4'h0;
      byte_q <= 3'h0;
      sh_q   <= 8'h00;
      adr_q  <= 8'h00;
      ptr_q  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        frm_q  <= 1'b1;
        bit_q  <= 4'h0;
        byte_q <= 3'h0;
      end else if (stop) begin
        frm_q <= 1'b0;
      end else if (slot) begin
        bit_q <= 4'h0;
        if (byte_q != 3'h7) begin
          byte_q <= byte_q + 3'h1;
        end
        if (byte_q == 3'h0) begin
          adr_q <= sh_q;
        end
        if (byte_q == 3'h1) begin
          ptr_q <= sh_q;
        end
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= {sh_q[6:0], sda};
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence high_two;
    scl [*2];
  endsequence

  addr_ack_a: assert property (slot && byte_q == 3'h0 && hit |-> !sda)
    else $error("own address not acknowledged");
  addr_nack_a: assert property (slot && byte_q == 3'h0 && !hit |-> sda)
    else $error("foreign address acknowledged");
  ptr_ack_a: assert property (slot && byte_q == 3'h1 && wr_ok |-> !sda)
    else $error("pointer byte not acknowledged");
  recall_nack_a: assert property (slot && wr_ok && recall |-> sda)
    else $error("recall byte acknowledged");
  data_ack_a: assert property (slot && wr_ok && byte_q >= 3'h2 && !recall |-> !sda)
    else $error("write data byte not acknowledged");
  hold_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device changed data while clock high");
  idle_quiet_a: assert property (s_sda_oe |-> frm_q)
    else $error("device drives outside a frame");
  ack_held_a: assert property (slot && s_sda_oe |-> s_sda_oe throughout high_two)
    else $error("acknowledge not held through clock high");
endmodule
`default_nettype wire

// *** verif/test_gamma_buffer_i2c_register_access.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gb_cfg.svh"
module test_gamma_buffer_i2c_register_access;
  localparam int unsigned NV = 200;
  logic         clk = 1'b0;
  logic         resetn;
  logic [11:0]  paddr;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         err;
  logic         address_select_pin;
  logic         dis;
  logic [149:0] dac;
  logic         nvb;
  int           bad_count = 0;
  int           checked = 0;
  int           cycles = 0;

  gb_link_if link ();
  gb_host #(.NV_CYC(NV)) gb_host_i (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  gb_dev #(.NV_CYC(NV)) gb_dev_i (.clk(clk), .resetn(resetn), .link(link),
    .address_select_pin(address_select_pin), .outputs_disabled(dis), .dac_values(dac), .nv_busy(nvb));
  gb_link_chk gb_link_chk_i (.clk(clk), .resetn(resetn), .scl(link.scl), .m_sda_o(link.m_sda_o),
    .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .sda(link.sda),
    .address_select_pin(address_select_pin));

  always #2.5 clk = !clk;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs about 30k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stands until pready is seen high at a rising edge; only the run timeout ends a wait
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [7:0] p, input logic [4:0] c, input logic rd, input logic a,
                     output logic [31:0] st);
    xfer(`GB_REG_CMD, 1'b1, {7'h0, a, 3'h0, c, p, 6'h0, rd, 1'b1}, st);
    do begin
      xfer(`GB_REG_STAT, 1'b0, 32'h0, st);
    end while (st[0] !== 1'b0);
  endtask

  task automatic wbuf(input int j, input logic [31:0] d);
    logic [31:0] r;
    xfer(12'h040 + 12'(j * 4), 1'b1, d, r);
  endtask

  function automatic logic [31:0] ch(input int i);
    return {22'h0, dac[(i - 1) * 10 +: 10]};
  endfunction

  initial begin
    logic [31:0] r;
    logic [31:0] st;
    logic [9:0]  v [1:15];
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    address_select_pin = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(`GB_REG_DIV, 1'b0, 32'h0, r);
    check(r, 32'h7d);
    xfer(12'h0f0, 1'b0, 32'h0, r);
    check({31'h0, err}, 32'h1);
    xfer(`GB_REG_DIV, 1'b1, 32'h8, r);
    $display("Test host registers done");
    // Reserved upper bits set on purpose, they must never reach the device
    for (int i = 1; i <= 15; i++) begin
      v[i] = 10'(i * 67 + 3);
      wbuf(i - 1, {16'h0, 6'h2f, v[i]});
    end
    run(8'h01, 5'd15, 1'b0, 1'b0, st);
    check(st, 32'h0);
    for (int i = 1; i <= 15; i++) check(ch(i), {22'h0, v[i]});
    $display("Test burst write done");
    run(8'h01, 5'd15, 1'b1, 1'b0, st);
    for (int i = 1; i <= 15; i++) begin
      xfer(12'h040 + 12'(i * 4 - 4), 1'b0, 32'h0, r);
      check(r, {22'h0, v[i]});
    end
    $display("Test burst read done");
    wbuf(0, 32'h0155);
    run(8'h05, 5'd1, 1'b0, 1'b0, st);
    check(ch(5), 32'h155);
    check(ch(4) | (ch(6) << 10), {12'h0, v[6], v[4]});
    $display("Test single write done");
    wbuf(0, 32'h08ff);
    run(8'h00, 5'd1, 1'b0, 1'b0, st);
    check({31'h0, dis}, 32'h1);
    check(ch(1), {22'h0, v[1]});
    run(8'h00, 5'd2, 1'b1, 1'b0, st);
    xfer(12'h040, 1'b0, 32'h0, r);
    check(r, 32'h0800);
    xfer(12'h044, 1'b0, 32'h0, r);
    check(r, {22'h0, v[1]});
    wbuf(0, 32'h0000);
    run(8'h00, 5'd1, 1'b0, 1'b0, st);
    check({31'h0, dis}, 32'h0);
    $display("Test control done");
    wbuf(0, 32'h42a5);
    run(8'h03, 5'd1, 1'b0, 1'b0, st);
    check({31'h0, nvb}, 32'h1);
    run(8'h03, 5'd1, 1'b0, 1'b0, st);
    check(st, 32'h4);
    repeat (NV + 20) @(posedge clk);
    check({31'h0, nvb}, 32'h0);
    wbuf(0, 32'h0011);
    run(8'h03, 5'd1, 1'b0, 1'b0, st);
    check(ch(3), 32'h011);
    wbuf(0, 32'h0600);
    run(8'h00, 5'd1, 1'b0, 1'b0, st);
    check(st, 32'h2);
    check(ch(3), 32'h2a5);
    check(ch(1), 32'h0);
    $display("Test store and recall done");
    wbuf(0, 32'h0123);
    run(8'h01, 5'd1, 1'b0, 1'b1, st);
    check(st, 32'h2);
    address_select_pin <= 1'b1;
    repeat (4) @(posedge clk);
    run(8'h01, 5'd1, 1'b0, 1'b1, st);
    check(ch(1), 32'h123);
    run(8'h01, 5'd16, 1'b0, 1'b1, st);
    check(st, 32'h4);
    $display("Test address select done");
    stop_test();
  end
endmodule
`default_nettype wire
